/* File: src/idgen_top.sv */
// Identification buffer generator: streams 256 words after a start pulse.
`timescale 1ns/1ns
`include "idgen_consts.svh"
// Notes on behaviour
// - Buffer sent like a single-sector read.
// - Reserved words and bits read zero.
// - Word 0 holds fixed general configuration.
// - Word 1 equals physical cylinder count.
// - Words 7-8 sector count, MSW first.
// - Sector count equals first invalid LBA.
// - Serial right-justified, padded with spaces.
// - Right ten unique ID; left ten user.
// - Firmware revision ASCII, big-endian words.
// - Words 27-46 hold user model string.
// - Word 47 fixed multiple-sector maximum.
// - Word 53 fixed validity flags.
// - Words 57-58 capacity, LSW first.
// - Word 63 low byte 07, high selected.
// - Word 64 reports PIO modes 0003.
// - Words 65-68 read 120 ns.
// - Word 80 major version 00fe.
// - Word 81 minor version 0021.
// - Words 89-90 report erase times.
// - Word 91 always reads zero.
// - Words 100-103 hold 48-bit max LBA.
// - Word 217 marks device non-rotating.
module idgen_top
    import idgen_pkg::*;
#(
    parameter logic [15:0] CYLINDERS = 16'h3fff,
    parameter logic [15:0] HEADS = 16'h0010,
    parameter logic [15:0] SECTORS = 16'h003f,
    parameter logic [79:0] FW_REV = 80'h0, // Arbitrary value; only 64 bits used.
    parameter logic [15:0] ERASE_TIME = 16'h0000,
    parameter logic [15:0] ENH_ERASE_TIME = 16'h0000,
    parameter logic [15:0] HW_RESET_RESULT = 16'h0000
) (
    input wire logic clk, // Clock, 125 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic start, // One-cycle pulse starting a buffer.
    input wire logic [79:0] uid, // Factory unique ID digits.
    input wire logic [79:0] user_id, // User serial part.
    input wire logic [319:0] model, // Model number text.
    input wire logic [15:0] cur_cyl, // Current cylinders.
    input wire logic [15:0] cur_heads, // Current heads.
    input wire logic [15:0] cur_spt, // Current sectors per track.
    input wire logic [7:0] mult_set, // Multiple sector count setting.
    input wire logic [2:0] mdma_sel, // One-hot selected DMA mode.
    output logic busy_r, // Buffer transfer in progress.
    output logic word_valid_r, // Output word valid.
    input wire logic word_ready, // Receiver takes the word.
    output logic [15:0] word_data_r, // Output word.
    output logic last_r // Marks word 255.
);
    idgen_state_t state_r;
    idgen_state_t state_nxt;
    logic [8:0] idx_r;
    logic [7:0] idx_lo;
    logic [15:0] tbl_word;
    logic [16:0] fifo_in;
    logic [16:0] fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic gen_push;
    logic [31:0] nsec;
    logic [31:0] cur_cap;
    logic [79:0] uid_pad;
    logic [79:0] user_pad;

    // Products wrap through truncation to 32 bits; they never saturate.
    assign nsec = 32'(32'(CYLINDERS) * 32'(HEADS) * 32'(SECTORS));
    assign cur_cap = 32'(48'(cur_cyl) * 48'(cur_heads) * 48'(cur_spt));

    // Replaces leading zero bytes with spaces to right-justify the text.
    function automatic logic [79:0] justify(input logic [79:0] s);
        logic lead;
        lead = 1'b1;
        justify = s;
        for (int i = 9; i >= 0; i--) begin
            if (lead && s[i*8 +: 8] == 8'h00) begin
                justify[i*8 +: 8] = `IDG_SPACE;
            end else begin
                lead = 1'b0;
            end
        end
    endfunction

    // An all-zero user field is the ten zero characters default.
    assign user_pad = (user_id == 80'h0) ? {10{`IDG_ASCII_ZERO}} : justify(user_id);
    assign uid_pad = justify(uid);
    assign idx_lo = idx_r[7:0];

    idgen_word u_word (
        .idx(idx_lo),
        .cyl(CYLINDERS),
        .heads(HEADS),
        .spt(SECTORS),
        .nsec(nsec),
        .user_id(user_pad),
        .uid(uid_pad),
        .fw_rev(FW_REV[63:0]),
        .model(model),
        .cur_cyl(cur_cyl),
        .cur_heads(cur_heads),
        .cur_spt(cur_spt),
        .cur_cap(cur_cap),
        .mult_set(mult_set),
        .mdma_sel(mdma_sel),
        .erase_t(ERASE_TIME),
        .enh_erase_t(ENH_ERASE_TIME),
        .hw_reset_res(HW_RESET_RESULT),
        .lba48_max({32'h0, nsec}),
        .word(tbl_word)
    );

    assign gen_push = (state_r == IDGEN_RUN) && fifo_in_ready;
    assign fifo_in = {idx_lo == `IDG_LAST_WORD, tbl_word};
    assign fifo_out_ready = !word_valid_r || word_ready;

    idgen_skid #(
        .WIDTH(17)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(state_r == IDGEN_RUN),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            IDGEN_IDLE: begin
                if (start) begin
                    state_nxt = IDGEN_RUN;
                end
            end
            IDGEN_RUN: begin
                if (gen_push && idx_lo == `IDG_LAST_WORD) begin
                    state_nxt = IDGEN_DRAIN;
                end
            end
            IDGEN_DRAIN: begin
                if (!fifo_out_valid && word_valid_r && word_ready && last_r) begin
                    state_nxt = IDGEN_IDLE;
                end
            end
            default: begin
                state_nxt = IDGEN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= IDGEN_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Words go out in order from 0 through 255, like one sector.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_r <= 9'h000;
        end else if (state_r == IDGEN_IDLE) begin
            idx_r <= 9'h000;
        end else if (gen_push && idx_r < `IDG_NWORDS) begin
            idx_r <= idx_r + 9'h001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_valid_r <= 1'b0;
            word_data_r <= 16'h0000;
            last_r <= 1'b0;
        end else if (fifo_out_ready) begin
            word_valid_r <= fifo_out_valid;
            word_data_r <= fifo_out_valid ? fifo_out[15:0] : 16'h0000;
            last_r <= fifo_out_valid && fifo_out[16];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt != IDGEN_IDLE);
        end
    end
endmodule

/* File: src/idgen_consts.svh */
// Constants for the identification buffer generator.
`ifndef IDGEN_CONSTS_SVH
`define IDGEN_CONSTS_SVH
`define IDG_NWORDS 9'h100
`define IDG_LAST_WORD 8'hff
`define IDG_W_GENCFG 8'h00
`define IDG_W_CYL 8'h01
`define IDG_W_HEADS 8'h03
`define IDG_W_SPT 8'h06
`define IDG_W_NSEC_MSW 8'h07
`define IDG_W_NSEC_LSW 8'h08
`define IDG_W_SER_FIRST 8'h0a
`define IDG_W_SER_LAST 8'h13
`define IDG_W_SER_UID 8'h0f
`define IDG_W_FW_FIRST 8'h17
`define IDG_W_FW_LAST 8'h1a
`define IDG_W_MODEL_FIRST 8'h1b
`define IDG_W_MODEL_LAST 8'h2e
`define IDG_W_MULTMAX 8'h2f
`define IDG_W_CAPAB 8'h31
`define IDG_W_PIOMODE 8'h33
`define IDG_W_VALID 8'h35
`define IDG_W_CUR_CYL 8'h36
`define IDG_W_CUR_HEADS 8'h37
`define IDG_W_CUR_SPT 8'h38
`define IDG_W_CAP_LSW 8'h39
`define IDG_W_CAP_MSW 8'h3a
`define IDG_W_MULTSET 8'h3b
`define IDG_W_LBA_LSW 8'h3c
`define IDG_W_LBA_MSW 8'h3d
`define IDG_W_MDMA 8'h3f
`define IDG_W_APIO 8'h40
`define IDG_W_CYC_FIRST 8'h41
`define IDG_W_CYC_LAST 8'h44
`define IDG_W_MAJOR 8'h50
`define IDG_W_MINOR 8'h51
`define IDG_W_FEAT0 8'h52
`define IDG_W_FEAT1 8'h53
`define IDG_W_FEAT2 8'h54
`define IDG_W_UDMA 8'h58
`define IDG_W_ERASE 8'h59
`define IDG_W_ENH_ERASE 8'h5a
`define IDG_W_APM 8'h5b
`define IDG_W_HWRESET 8'h5d
`define IDG_W_LBA48_FIRST 8'h64
`define IDG_W_LBA48_LAST 8'h67
`define IDG_W_ROTATION 8'hd9
`define IDG_V_GENCFG 16'h044a
`define IDG_V_MULTMAX 16'h8001
`define IDG_V_CAPAB 16'h0b00
`define IDG_V_PIOMODE 16'h0200
`define IDG_V_VALID 16'h0007
`define IDG_V_MULTSET_HI 8'h01
`define IDG_V_MDMA_LO 8'h07
`define IDG_V_APIO 16'h0003
`define IDG_V_CYCLE 16'h0078
`define IDG_V_MAJOR 16'h00fe
`define IDG_V_MINOR 16'h0021
`define IDG_V_FEAT0 16'h706b
`define IDG_V_FEAT1 16'h7408
`define IDG_V_FEAT2 16'h4000
`define IDG_V_UDMA 16'h007f
`define IDG_V_APM 16'h0000
`define IDG_V_ROTATION 16'h0001
`define IDG_V_ZERO 16'h0000
`define IDG_SPACE 8'h20
`define IDG_ASCII_ZERO 8'h30
`endif

/* File: src/idgen_pkg.sv */
// Types shared by the identification buffer generator.
package idgen_pkg;
    typedef enum logic [1:0] {
        IDGEN_IDLE = 2'h0,
        IDGEN_RUN = 2'h1,
        IDGEN_DRAIN = 2'h3
    } idgen_state_t;
endpackage

/* File: src/idgen_skid.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns
module idgen_skid #(
    parameter int WIDTH = 16
) (
    input wire logic clk, // Clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic in_valid, // Word offered.
    output logic in_ready, // Space for a word.
    input wire logic [WIDTH-1:0] in_data, // Word in.
    output logic out_valid, // Word available.
    input wire logic out_ready, // Receiver takes word.
    output logic [WIDTH-1:0] out_data // Word out.
);
    logic [WIDTH-1:0] mem_r [2];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rp_r];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule

/* File: src/idgen_word.sv */
// Combinational table of the identification buffer contents.
`timescale 1ns/1ns
`include "idgen_consts.svh"
module idgen_word (
    input wire logic [7:0] idx, // Word index.
    input wire logic [15:0] cyl, // Default cylinders.
    input wire logic [15:0] heads, // Default heads.
    input wire logic [15:0] spt, // Default sectors per track.
    input wire logic [31:0] nsec, // Total sectors.
    input wire logic [79:0] user_id, // User serial part.
    input wire logic [79:0] uid, // Factory unique ID.
    input wire logic [63:0] fw_rev, // Firmware revision text.
    input wire logic [319:0] model, // Model string.
    input wire logic [15:0] cur_cyl, // Current cylinders.
    input wire logic [15:0] cur_heads, // Current heads.
    input wire logic [15:0] cur_spt, // Current sectors per track.
    input wire logic [31:0] cur_cap, // Current capacity.
    input wire logic [7:0] mult_set, // Multiple sector setting.
    input wire logic [2:0] mdma_sel, // Selected multi-word DMA mode.
    input wire logic [15:0] erase_t, // Security erase time.
    input wire logic [15:0] enh_erase_t, // Enhanced erase time.
    input wire logic [15:0] hw_reset_res, // Hardware reset result.
    input wire logic [63:0] lba48_max, // Max 48-bit LBA.
    output logic [15:0] word // Word value.
);
    // Big-endian 16-bit pick from a string, character 0 leftmost.
    function automatic logic [15:0] pick(input logic [319:0] s, input logic [7:0] n,
                                         input logic [7:0] total);
        logic [8:0] sh;
        // Reversed word index times sixteen, built wide enough for the 40-byte model string.
        sh = 9'({total - 8'h1 - n, 4'h0});
        pick = 16'(s >> sh);
    endfunction

    always_comb begin
        word = `IDG_V_ZERO;
        if (idx == `IDG_W_GENCFG) begin
            word = `IDG_V_GENCFG;
        end else if (idx == `IDG_W_CYL) begin
            word = cyl;
        end else if (idx == `IDG_W_HEADS) begin
            word = heads;
        end else if (idx == `IDG_W_SPT) begin
            word = spt;
        end else if (idx == `IDG_W_NSEC_MSW) begin
            word = nsec[31:16];
        end else if (idx == `IDG_W_NSEC_LSW) begin
            word = nsec[15:0];
        end else if (idx >= `IDG_W_SER_FIRST && idx < `IDG_W_SER_UID) begin
            word = pick({240'h0, user_id}, idx - `IDG_W_SER_FIRST, 8'h5);
        end else if (idx >= `IDG_W_SER_UID && idx <= `IDG_W_SER_LAST) begin
            word = pick({240'h0, uid}, idx - `IDG_W_SER_UID, 8'h5);
        end else if (idx >= `IDG_W_FW_FIRST && idx <= `IDG_W_FW_LAST) begin
            word = pick({256'h0, fw_rev}, idx - `IDG_W_FW_FIRST, 8'h4);
        end else if (idx >= `IDG_W_MODEL_FIRST && idx <= `IDG_W_MODEL_LAST) begin
            word = pick(model, idx - `IDG_W_MODEL_FIRST, 8'h14);
        end else if (idx == `IDG_W_MULTMAX) begin
            word = `IDG_V_MULTMAX;
        end else if (idx == `IDG_W_CAPAB) begin
            word = `IDG_V_CAPAB;
        end else if (idx == `IDG_W_PIOMODE) begin
            word = `IDG_V_PIOMODE;
        end else if (idx == `IDG_W_VALID) begin
            word = `IDG_V_VALID;
        end else if (idx == `IDG_W_CUR_CYL) begin
            word = cur_cyl;
        end else if (idx == `IDG_W_CUR_HEADS) begin
            word = cur_heads;
        end else if (idx == `IDG_W_CUR_SPT) begin
            word = cur_spt;
        end else if (idx == `IDG_W_CAP_LSW) begin
            word = cur_cap[15:0];
        end else if (idx == `IDG_W_CAP_MSW) begin
            word = cur_cap[31:16];
        end else if (idx == `IDG_W_MULTSET) begin
            word = {`IDG_V_MULTSET_HI, mult_set};
        end else if (idx == `IDG_W_LBA_LSW) begin
            word = nsec[15:0];
        end else if (idx == `IDG_W_LBA_MSW) begin
            word = nsec[31:16];
        end else if (idx == `IDG_W_MDMA) begin
            word = {5'h00, mdma_sel, `IDG_V_MDMA_LO};
        end else if (idx == `IDG_W_APIO) begin
            word = `IDG_V_APIO;
        end else if (idx >= `IDG_W_CYC_FIRST && idx <= `IDG_W_CYC_LAST) begin
            word = `IDG_V_CYCLE;
        end else if (idx == `IDG_W_MAJOR) begin
            word = `IDG_V_MAJOR;
        end else if (idx == `IDG_W_MINOR) begin
            word = `IDG_V_MINOR;
        end else if (idx == `IDG_W_FEAT0) begin
            word = `IDG_V_FEAT0;
        end else if (idx == `IDG_W_FEAT1) begin
            word = `IDG_V_FEAT1;
        end else if (idx == `IDG_W_FEAT2) begin
            word = `IDG_V_FEAT2;
        end else if (idx == `IDG_W_UDMA) begin
            word = `IDG_V_UDMA;
        end else if (idx == `IDG_W_ERASE) begin
            word = erase_t;
        end else if (idx == `IDG_W_ENH_ERASE) begin
            word = enh_erase_t;
        end else if (idx == `IDG_W_APM) begin
            word = `IDG_V_APM;
        end else if (idx == `IDG_W_HWRESET) begin
            word = hw_reset_res;
        end else if (idx >= `IDG_W_LBA48_FIRST && idx <= `IDG_W_LBA48_LAST) begin
            word = 16'(lba48_max >> {idx - `IDG_W_LBA48_FIRST, 4'h0});
        end else if (idx == `IDG_W_ROTATION) begin
            word = `IDG_V_ROTATION;
        end
    end
endmodule

/* File: verif/idgen_top_props.sv */
// Concurrent checks on the ports of the identification buffer generator.
`timescale 1ns/1ns
module idgen_top_props (
    input wire logic clk, // Clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic start, // Start pulse.
    input wire logic busy_r, // Transfer in progress.
    input wire logic word_valid_r, // Word offered.
    input wire logic word_ready, // Receiver takes word.
    input wire logic [15:0] word_data_r, // Word offered.
    input wire logic last_r // Last word marker.
);
    logic [8:0] taken_r;

    // Counts words taken since the accepted start.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            taken_r <= 9'h000;
        end else if (start && !busy_r) begin
            taken_r <= 9'h000;
        end else if (word_valid_r && word_ready) begin
            taken_r <= taken_r + 9'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_start_busy;
        start && !busy_r |=> busy_r;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not accepted");

    property p_first_word;
        start && !busy_r |=> !word_valid_r ##1 !word_valid_r ##1
            (word_valid_r && word_data_r == 16'h044a);
    endproperty
    a_first_word: assert property (p_first_word) else $error("first word late or wrong");

    property p_hold;
        word_valid_r && !word_ready |=> word_valid_r && $stable(word_data_r) && $stable(last_r);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed while stalled");

    property p_last_zero;
        last_r |-> word_valid_r && word_data_r == 16'h0000;
    endproperty
    a_last_zero: assert property (p_last_zero) else $error("last word not zero");

    property p_last_count;
        word_valid_r |-> (last_r == (taken_r == 9'h0ff));
    endproperty
    a_last_count: assert property (p_last_count) else $error("last marker misplaced");

    property p_end;
        word_valid_r && word_ready && last_r |=> !word_valid_r ##1 !busy_r;
    endproperty
    a_end: assert property (p_end) else $error("buffer did not end");

    property p_valid_busy;
        word_valid_r |-> busy_r;
    endproperty
    a_valid_busy: assert property (p_valid_busy) else $error("word outside transfer");

    property p_busy_fall;
        $fell(busy_r) |-> $past(last_r && word_ready);
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy dropped early");

    c_start: cover property (start && !busy_r);
    c_stall: cover property (word_valid_r && !word_ready);
    c_restart: cover property (start && busy_r);
    c_last: cover property (last_r && word_ready);
endmodule

bind idgen_top idgen_top_props props_u (
    .clk(clk),
    .rst(rst),
    .start(start),
    .busy_r(busy_r),
    .word_valid_r(word_valid_r),
    .word_ready(word_ready),
    .word_data_r(word_data_r),
    .last_r(last_r)
);

/* File: verif/idgen_host_model.sv */
// Host reading the data port: takes words, stalling at random when asked.
`timescale 1ns/1ns
module idgen_host_model (
    input wire logic clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic word_valid_r, // Word offered.
    input wire logic [15:0] word_data_r, // Word offered.
    input wire logic last_r, // Last word marker.
    input wire logic stall_en, // Stall at random when high.
    output logic word_ready // Host takes word.
);
    logic [15:0] got_q[$];
    logic last_q[$];

    initial word_ready = 1'b1;

    // Every taken word is kept whole; the bench judges what the host may rely on.
    always @(posedge clk) begin
        if (!rst && word_valid_r && word_ready) begin
            got_q.push_back(word_data_r);
            last_q.push_back(last_r);
        end
    end

    always @(posedge clk) begin
        #1 word_ready = stall_en ? 1'($urandom % 2) : 1'b1;
    end
endmodule

/* File: verif/idgen_top_tb_top.sv */
// Self-checking bench for the identification buffer generator.
`timescale 1ns/1ns
module idgen_top_tb_top;
    localparam logic [15:0] CYL = 16'h1234;
    localparam logic [15:0] HDS = 16'h0010;
    localparam logic [15:0] SPT = 16'h003f;
    localparam logic [15:0] ERT = 16'h0005;
    localparam logic [15:0] EERT = 16'h0009;
    localparam logic [15:0] HWR = 16'h600b;
    localparam logic [79:0] FWR = 80'h0000_3132_2e33_3461_2d62;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic stall_en = 1'b0;
    logic [79:0] uid = '0;
    logic [79:0] user_id = '0;
    logic [319:0] model = '0;
    logic [15:0] cur_cyl = '0;
    logic [15:0] cur_heads = '0;
    logic [15:0] cur_spt = '0;
    logic [7:0] mult_set = '0;
    logic [2:0] mdma_sel = 3'h1;
    logic busy_r;
    logic word_valid_r;
    logic word_ready;
    logic last_r;
    logic [15:0] word_data_r;
    logic [15:0] exp_w [256];
    int n_mismatch = 0;
    int num_checks = 0;

    always #4 clk = ~clk;

    idgen_top #(.CYLINDERS(CYL), .HEADS(HDS), .SECTORS(SPT), .ERASE_TIME(ERT),
        .ENH_ERASE_TIME(EERT), .HW_RESET_RESULT(HWR), .FW_REV(FWR)) dut_u (
        .clk(clk), .rst(rst), .start(start), .uid(uid), .user_id(user_id), .model(model),
        .cur_cyl(cur_cyl), .cur_heads(cur_heads), .cur_spt(cur_spt), .mult_set(mult_set),
        .mdma_sel(mdma_sel), .busy_r(busy_r), .word_valid_r(word_valid_r),
        .word_ready(word_ready), .word_data_r(word_data_r), .last_r(last_r));

    idgen_host_model host_u (.clk(clk), .rst(rst), .word_valid_r(word_valid_r),
        .word_data_r(word_data_r), .last_r(last_r), .stall_en(stall_en),
        .word_ready(word_ready));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic build_exp();
        logic [63:0] p;
        logic [63:0] c;
        logic [7:0] u;
        bit lead;
        p = 64'(CYL) * 64'(HDS) * 64'(SPT);
        c = 64'(cur_cyl) * 64'(cur_heads) * 64'(cur_spt);
        lead = 1'b1;
        foreach (exp_w[i]) exp_w[i] = 16'h0000;
        exp_w[0] = 16'h044a;
        exp_w[1] = CYL;
        exp_w[3] = HDS;
        exp_w[6] = SPT;
        exp_w[7] = p[31:16];
        exp_w[8] = p[15:0];
        for (int k = 0; k < 10; k++) begin
            u = uid[79-8*k -: 8];
            lead = lead && (u == 8'h00);
            exp_w[15+k/2][15-8*(k%2) -: 8] = lead ? 8'h20 : u;
            u = (user_id == '0) ? 8'h30 : user_id[79-8*k -: 8];
            exp_w[10+k/2][15-8*(k%2) -: 8] = u;
        end
        for (int k = 0; k < 4; k++) exp_w[23+k] = FWR[63-16*k -: 16];
        for (int k = 0; k < 20; k++) exp_w[27+k] = model[319-16*k -: 16];
        exp_w[47] = 16'h8001;
        exp_w[49] = 16'h0b00;
        exp_w[51] = 16'h0200;
        exp_w[53] = 16'h0007;
        exp_w[54] = cur_cyl;
        exp_w[55] = cur_heads;
        exp_w[56] = cur_spt;
        exp_w[57] = c[15:0];
        exp_w[58] = c[31:16];
        exp_w[59] = {8'h01, mult_set};
        exp_w[60] = p[15:0];
        exp_w[61] = p[31:16];
        exp_w[63] = {5'h00, mdma_sel, 8'h07};
        exp_w[64] = 16'h0003;
        for (int k = 65; k <= 68; k++) exp_w[k] = 16'h0078;
        exp_w[80] = 16'h00fe;
        exp_w[81] = 16'h0021;
        exp_w[82] = 16'h706b;
        exp_w[83] = 16'h7408;
        exp_w[84] = 16'h4000;
        exp_w[88] = 16'h007f;
        exp_w[89] = ERT;
        exp_w[90] = EERT;
        exp_w[93] = HWR;
        for (int k = 0; k < 4; k++) exp_w[100+k] = p[16*k +: 16];
        exp_w[217] = 16'h0001;
    endtask

    task automatic rand_in();
        int n;
        n = $urandom % 10;
        for (int k = 0; k < 10; k++) begin
            uid[79-8*k -: 8] = (k < n) ? 8'h00 : 8'(8'h30 + $urandom % 10);
            user_id[79-8*k -: 8] = 8'(8'h30 + $urandom % 10);
        end
        for (int k = 0; k < 40; k++) model[319-8*k -: 8] = 8'(8'h20 + $urandom % 95);
        cur_cyl = 16'($urandom);
        cur_heads = 16'($urandom);
        cur_spt = 16'($urandom);
        mult_set = 8'($urandom);
    endtask

    task automatic run_buf(input bit extra, input int tnum);
        int i;
        build_exp();
        host_u.got_q.delete();
        host_u.last_q.delete();
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        i = 0;
        while (host_u.got_q.size() < 256 && i < 5000) begin
            @(posedge clk);
            #1 i++;
            start = extra && (i == 20);
        end
        if (i == 5000) begin
            n_mismatch++;
            print_verdict();
        end
        i = 0;
        while (busy_r !== 1'b0 && i < 10) begin
            @(posedge clk);
            #1 i++;
        end
        if (i == 10) begin
            n_mismatch++;
            print_verdict();
        end
        repeat (6) @(posedge clk);
        #1 check({15'h0000, word_valid_r}, 16'h0000);
        check(16'(host_u.got_q.size()), 16'h0100);
        for (int k = 0; k < 256; k++) begin
            check(host_u.got_q[k], exp_w[k]);
            check({15'h0000, host_u.last_q[k]}, {15'h0000, k == 255});
        end
        $display("test %0d done", tnum);
    endtask

    initial begin
        void'($urandom(55));
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        for (int k = 0; k < 3; k++) begin
            rand_in();
            if (k == 0) user_id = '0;
            mdma_sel = 3'h1 << k;
            stall_en = (k != 0);
            run_buf(k == 2, k);
        end
        // A reset in mid-buffer must clear the port and allow a fresh buffer.
        rand_in();
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        repeat (60) @(posedge clk);
        #1 rst = 1'b1;
        @(posedge clk);
        #1 check({13'h0000, busy_r, word_valid_r, last_r}, 16'h0000);
        rst = 1'b0;
        run_buf(1'b0, 3);
        print_verdict();
    end
endmodule
